// File: fpu_dec_regs.svh
// Notes on behaviour
// - Divide forms: n/top into n, top/n into top, top by double or single real; 24 clocks.
// - Divide-and-pop writes n/top into register n, then pops.
// - Reversed divide swaps dividend and divisor; memory real forms use reg field 111.
// - Reversed divide-and-pop writes top/n into register n, then pops.
// - Integer divide: top over 32-bit or 16-bit memory integer, 34 clocks.
// - Reversed integer divide: memory integer over top into top, 34 clocks.
// - Free register marks register n empty without touching data, 4 clocks.
// - Move on carry set copies register n into register 0 only when carry is one.
// - Move on carry clear copies register n into register 0 only when carry is zero.
// - Waiting clear-exceptions waits for pending activity; plain form clears 2 clocks after issue without waiting.
// - Add-and-pop writes n plus top into register n, then pops.
// - Compare-to-integer-flags compares top with n, sets integer flags, then pops.
// - Compare-and-pop-twice compares top with register 1, sets condition codes, pops.
`ifndef FPU_DEC_REGS_SVH
`define FPU_DEC_REGS_SVH

// ----------------------------------------
// Opcode bytes
// ----------------------------------------
`define OPC_D8        8'hD8
`define OPC_DA        8'hDA
`define OPC_DB        8'hDB
`define OPC_DC        8'hDC
`define OPC_DD        8'hDD
`define OPC_DE        8'hDE
`define OPC_DF        8'hDF

// ----------------------------------------
// Second byte fields and patterns
// ----------------------------------------
`define MOD_HI        7
`define MOD_LO        6
`define REG_HI        5
`define REG_LO        3
`define RM_HI         2
`define RM_LO         0
`define MOD_REG       2'h3
`define RF_DIV        4'hF
`define RF_DIV_B      3
`define RF_GRP_C0     5'h18
`define RF_GRP_F0     5'h1E
`define RSEL_DIV      2'h3
`define MODRM_CLEX    8'hE2
`define MODRM_COMPP   8'hD9

// ----------------------------------------
// Reset values and clock counts
// ----------------------------------------
`define TOP_RST       3'h0
`define TAG_RST       8'hFF
`define FP_DIVIDE_CLKS     6'h18
`define FP_INTEGER_DIVIDE_CLKS    6'h22
`define FREE_CLKS     6'h04
`define SIMPLE_CLKS   6'h02

`endif

// File: fpu_dec_pkg.sv
package fpu_dec_pkg;

    typedef enum logic [3:0] {
        OP_NONE,
        OP_DIV,
        OP_IDIV,
        OP_ADD,
        OP_FREE,
        OP_CMOV,
        OP_CLEX,
        OP_COMI,
        OP_COMPP
    } op_kind_t;

    typedef enum logic [2:0] {
        MEM_NONE,
        MEM_DOUBLE_REAL,
        MEM_SINGLE_REAL,
        MEM_INT32,
        MEM_INT16
    } mem_fmt_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_EXEC
    } seq_state_t;

endpackage : fpu_dec_pkg

// File: exec_timer.sv
`timescale 1ns/1ps
`default_nettype none
module exec_timer
(
    input  wire logic       clk_i,     // Core clock
    input  wire logic       srst_i,    // Sync reset
    input  wire logic       start_i,   // Load count
    input  wire logic [5:0] cycles_i,  // Clocks to run
    output logic            done_o     // Last cycle
);
    logic [5:0] cnt;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            cnt <= 6'h00;
        else if (start_i)
            cnt <= cycles_i;
        else if (cnt != 6'h00)
            cnt <= cnt - 6'h01;
    end

    assign done_o = (cnt == 6'h01);
endmodule : exec_timer
`default_nettype wire

// File: fpu_divide_cmov_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "fpu_dec_regs.svh"
module fpu_divide_cmov_decode
    import fpu_dec_pkg::*;
(
    input  wire logic       clk_i,          // Core clock
    input  wire logic       srst_i,         // Sync reset
    input  wire logic       issue_valid_i,  // Instruction offered
    input  wire logic [7:0] opcode_i,       // First opcode byte
    input  wire logic [7:0] modrm_i,        // Second byte
    input  wire logic       wait_prefix_i,  // Wait prefix present
    input  wire logic       carry_flag_i,   // Integer carry flag
    input  wire logic       fp_pending_i,   // FP activity pending
    output logic            issue_ready_o,  // Can take instruction
    output logic            illegal_o,      // Unhandled encoding
    output var op_kind_t    op_o,           // Operation kind
    output var mem_fmt_t    mem_fmt_o,      // Memory operand format
    output logic            mem_first_o,    // Memory is dividend
    output logic [2:0]      dst_o,          // Physical destination
    output logic [2:0]      opa_o,          // Physical first operand
    output logic [2:0]      opb_o,          // Physical second operand
    output logic            write_en_o,     // Result is written
    output logic [1:0]      pop_cnt_o,      // Pops at completion
    output logic            done_o,         // Completion strobe
    output logic            clear_exc_o,    // Clear exception flags
    output logic [2:0]      top_o,          // Top-of-stack pointer
    output logic [7:0]      tag_empty_o     // Empty tag per register
);
    localparam int DIV_LAT  = 24;
    localparam int IDIV_LAT = 34;
    localparam int FREE_LAT = 4;
    localparam int SIMP_LAT = 2;

    seq_state_t st;
    op_kind_t   d_op;
    mem_fmt_t   d_mem;
    logic       d_legal, d_wr, d_memfirst, d_wait, reg_form, fire, start, is_dc;
    logic [2:0] d_dst, d_opa, d_opb, phys_n, rsel, top;
    logic [1:0] d_pop;
    logic [5:0] d_lat, lat_q, start_lat;
    logic [7:0] tag_empty;

    assign fire          = issue_valid_i && (st == ST_IDLE);
    assign issue_ready_o = (st == ST_IDLE);
    assign top_o         = top;
    assign tag_empty_o   = tag_empty;
    assign clear_exc_o   = done_o && (op_o == OP_CLEX);

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    always_comb
    begin
        reg_form   = (modrm_i[`MOD_HI:`MOD_LO] == `MOD_REG);
        rsel       = modrm_i[`REG_HI:`REG_LO];
        phys_n     = top + modrm_i[`RM_HI:`RM_LO];
        is_dc      = (opcode_i == `OPC_DC);
        d_legal    = 1'b0;
        d_op       = OP_NONE;
        d_mem      = MEM_NONE;
        d_memfirst = 1'b0;
        d_dst      = top;
        d_opa      = top;
        d_opb      = phys_n;
        d_wr       = 1'b0;
        d_pop      = 2'h0;
        d_lat      = `SIMPLE_CLKS;
        d_wait     = 1'b0;
        if (!reg_form && rsel[2:1] == `RSEL_DIV &&
            (opcode_i == `OPC_D8 || is_dc || opcode_i == `OPC_DA || opcode_i == `OPC_DE))
        begin
            d_legal    = 1'b1;
            d_wr       = 1'b1;
            d_opb      = top;
            d_memfirst = rsel[0];
            if (opcode_i == `OPC_D8 || is_dc)
            begin
                d_op  = OP_DIV;
                d_mem = is_dc ? MEM_DOUBLE_REAL : MEM_SINGLE_REAL;
                d_lat = `FP_DIVIDE_CLKS;
            end
            else
            begin
                d_op  = OP_IDIV;
                d_mem = (opcode_i == `OPC_DA) ? MEM_INT32 : MEM_INT16;
                d_lat = `FP_INTEGER_DIVIDE_CLKS;
            end
        end
        else if (reg_form)
        begin
            case (opcode_i)
                `OPC_D8, `OPC_DC, `OPC_DE:
                begin
                    if (modrm_i[7:4] == `RF_DIV)
                    begin
                        d_legal = 1'b1;
                        d_op    = OP_DIV;
                        d_wr    = 1'b1;
                        d_lat   = `FP_DIVIDE_CLKS;
                        if (opcode_i == `OPC_DE)
                        begin
                            d_dst = phys_n;
                            d_opa = modrm_i[`RF_DIV_B] ? phys_n : top;
                            d_opb = modrm_i[`RF_DIV_B] ? top : phys_n;
                            d_pop = 2'h1;
                        end
                        else
                        begin
                            d_dst = modrm_i[`RF_DIV_B] ? phys_n : top;
                            d_opa = is_dc ? phys_n : top;
                            d_opb = is_dc ? top : phys_n;
                        end
                    end
                    else if (opcode_i == `OPC_DE && modrm_i[7:3] == `RF_GRP_C0)
                    begin
                        d_legal = 1'b1;
                        d_op    = OP_ADD;
                        d_dst   = phys_n;
                        d_opa   = phys_n;
                        d_opb   = top;
                        d_wr    = 1'b1;
                        d_pop   = 2'h1;
                    end
                    else if (opcode_i == `OPC_DE && modrm_i == `MODRM_COMPP)
                    begin
                        d_legal = 1'b1;
                        d_op    = OP_COMPP;
                        d_opb   = top + 3'h1;
                        d_pop   = 2'h2;
                    end
                end
                `OPC_DA, `OPC_DB:
                begin
                    if (modrm_i[7:3] == `RF_GRP_C0)
                    begin
                        d_legal = 1'b1;
                        d_op    = OP_CMOV;
                        d_opa   = phys_n;
                        d_wr    = (opcode_i == `OPC_DA) ? carry_flag_i : !carry_flag_i;
                    end
                    else if (opcode_i == `OPC_DB && modrm_i == `MODRM_CLEX)
                    begin
                        d_legal = 1'b1;
                        d_op    = OP_CLEX;
                        d_wait  = wait_prefix_i;
                    end
                end
                `OPC_DD:
                begin
                    if (modrm_i[7:3] == `RF_GRP_C0)
                    begin
                        d_legal = 1'b1;
                        d_op    = OP_FREE;
                        d_dst   = phys_n;
                        d_lat   = `FREE_CLKS;
                    end
                end
                `OPC_DF:
                begin
                    if (modrm_i[7:3] == `RF_GRP_F0)
                    begin
                        d_legal = 1'b1;
                        d_op    = OP_COMI;
                        d_pop   = 2'h1;
                    end
                end
                default:
                begin
                    d_legal = 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Sequencing
    // ----------------------------------------
    assign start = (fire && d_legal && !(d_wait && fp_pending_i)) ||
                   (st == ST_WAIT && !fp_pending_i);
    assign start_lat = (st == ST_WAIT) ? lat_q : d_lat;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            st <= ST_IDLE;
        else
        begin
            unique case (st)
                ST_IDLE:
                    if (fire && d_legal)
                        st <= (d_wait && fp_pending_i) ? ST_WAIT : ST_EXEC;
                ST_WAIT:
                    if (!fp_pending_i)
                        st <= ST_EXEC;
                ST_EXEC:
                    if (done_o)
                        st <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            illegal_o <= 1'b0;
        else
            illegal_o <= fire && !d_legal;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            op_o        <= OP_NONE;
            mem_fmt_o   <= MEM_NONE;
            mem_first_o <= 1'b0;
            dst_o       <= 3'h0;
            opa_o       <= 3'h0;
            opb_o       <= 3'h0;
            write_en_o  <= 1'b0;
            pop_cnt_o   <= 2'h0;
            lat_q       <= `SIMPLE_CLKS;
        end
        else if (fire && d_legal)
        begin
            op_o        <= d_op;
            mem_fmt_o   <= d_mem;
            mem_first_o <= d_memfirst;
            dst_o       <= d_dst;
            opa_o       <= d_opa;
            opb_o       <= d_opb;
            write_en_o  <= d_wr;
            pop_cnt_o   <= d_pop;
            lat_q       <= d_lat;
        end
    end

    exec_timer u_timer
    (
        .clk_i    (clk_i),
        .srst_i   (srst_i),
        .start_i  (start),
        .cycles_i (start_lat),
        .done_o   (done_o)
    );

    // ----------------------------------------
    // Stack pointer and tags
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            top <= `TOP_RST;
        else if (done_o)
            top <= top + {1'b0, pop_cnt_o};
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
            tag_empty <= `TAG_RST;
        else if (done_o)
        begin
            tag_empty[dst_o] <= (op_o == OP_FREE) ? 1'b1 : (tag_empty[dst_o] && !write_en_o);
            if (pop_cnt_o != 2'h0)
                tag_empty[top] <= 1'b1;
            if (pop_cnt_o == 2'h2)
                tag_empty[top + 3'h1] <= 1'b1;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence s_clex_held;
        (st == ST_WAIT) && fp_pending_i;
    endsequence
    sequence s_clex_release;
        (st == ST_WAIT) && !fp_pending_i;
    endsequence

    property p_div_time;
        fire && d_legal && d_op == OP_DIV |-> !done_o [*8] ##(DIV_LAT - 7) done_o;
    endproperty
    a_div_time: assert property (p_div_time) else $error("divide not done in 24 clocks");

    property p_idiv_time;
        fire && d_legal && d_op == OP_IDIV |-> ##IDIV_LAT done_o && op_o == OP_IDIV;
    endproperty
    a_idiv_time: assert property (p_idiv_time) else $error("integer divide not done in 34 clocks");

    property p_free_tag;
        fire && d_legal && d_op == OP_FREE |-> ##FREE_LAT done_o ##1 tag_empty_o[dst_o];
    endproperty
    a_free_tag: assert property (p_free_tag) else $error("freed register not empty");

    property p_cmov_set;
        fire && opcode_i == `OPC_DA && reg_form && d_op == OP_CMOV |=> write_en_o == $past(carry_flag_i);
    endproperty
    a_cmov_set: assert property (p_cmov_set) else $error("move on carry set wrong");

    property p_cmov_clr;
        fire && opcode_i == `OPC_DB && d_op == OP_CMOV |=> write_en_o != $past(carry_flag_i);
    endproperty
    a_cmov_clr: assert property (p_cmov_clr) else $error("move on carry clear wrong");

    property p_clex_wait;
        s_clex_held |-> !clear_exc_o;
    endproperty
    a_clex_wait: assert property (p_clex_wait) else $error("exceptions cleared while pending");

    property p_clex_go;
        s_clex_release |-> ##SIMP_LAT clear_exc_o;
    endproperty
    a_clex_go: assert property (p_clex_go) else $error("exceptions not cleared after wait");

    property p_pop_top;
        done_o |=> top_o == 3'($past(top_o) + {1'b0, $past(pop_cnt_o)}) && ($past(pop_cnt_o) == 2'h0 || tag_empty_o[$past(top_o)]);
    endproperty
    a_pop_top: assert property (p_pop_top) else $error("pop did not advance top");

    property p_reg_map;
        fire && d_legal && d_op == OP_FREE |=> dst_o == 3'($past(top_o) + $past(modrm_i[2:0]));
    endproperty
    a_reg_map: assert property (p_reg_map) else $error("register field mapped wrongly");

    property p_divrp;
        fire && opcode_i == `OPC_DE && modrm_i[7:3] == `RF_GRP_F0 |=> opa_o == top_o && dst_o == opb_o && pop_cnt_o == 2'h1;
    endproperty
    a_divrp: assert property (p_divrp) else $error("reversed divide pop wrong");

    property p_divp;
        fire && opcode_i == `OPC_DE && modrm_i[7:4] == `RF_DIV && modrm_i[3] |=> opb_o == top_o && dst_o == opa_o && pop_cnt_o == 2'h1;
    endproperty
    a_divp: assert property (p_divp) else $error("divide pop wrong");

    property p_compp;
        fire && opcode_i == `OPC_DE && modrm_i == `MODRM_COMPP |=> pop_cnt_o == 2'h2 && opb_o == 3'(top_o + 3'h1) && !write_en_o;
    endproperty
    a_compp: assert property (p_compp) else $error("compare pop twice wrong");
endmodule : fpu_divide_cmov_decode
`default_nettype wire

// File: issue_source.sv
`timescale 1ns/1ps
`default_nettype none
module issue_source
(
    input  wire logic       clk_i,          // Core clock
    input  wire logic       issue_ready_i,  // Decoder can take
    output logic            issue_valid_o,  // Instruction offered
    output logic [7:0]      opcode_o,       // First opcode byte
    output logic [7:0]      modrm_o,        // Second byte
    output logic            wait_prefix_o,  // Waiting form
    output logic            carry_flag_o    // Integer carry flag
);
    initial
    begin
        issue_valid_o = 1'b0;
        opcode_o = 8'h00;
        modrm_o = 8'h00;
        wait_prefix_o = 1'b0;
        carry_flag_o = 1'b0;
    end

    // ----------------------------------------
    // Offer held until taken at a rising edge
    // ----------------------------------------
    task automatic send(input logic [7:0] opc, input logic [7:0] md, input logic wp, input logic cf);
        while (issue_ready_i !== 1'b1)
            @(negedge clk_i);
        issue_valid_o = 1'b1;
        opcode_o = opc;
        modrm_o = md;
        wait_prefix_o = wp;
        carry_flag_o = cf;
        @(posedge clk_i);
        @(negedge clk_i);
        // Stale fields inverted once released
        issue_valid_o = 1'b0;
        opcode_o = ~opc;
        modrm_o = ~md;
        wait_prefix_o = ~wp;
        carry_flag_o = ~cf;
    endtask : send
endmodule : issue_source
`default_nettype wire

// File: tb_fpu_divide_cmov_decode.sv
`timescale 1ns/1ps
`default_nettype none
module tb_fpu_divide_cmov_decode
    import fpu_dec_pkg::*;
;
    logic       clk, srst, valid, wp, cf, pending, ready, illegal, mem_first, we, done, clr;
    logic [7:0] opcode, modrm, tags, m_tag;
    logic [2:0] dst, opa, opb, top, e_dst, e_opa, e_opb;
    logic [1:0] pop, e_pop;
    logic       e_mf, e_we, k_ops;
    op_kind_t   op, e_op;
    mem_fmt_t   fmt, e_fmt;
    int         error_cnt, cmp_count, m_top, e_n, seed;

    localparam logic [15:0] op_table [23] = '{16'hD8F0, 16'hD8F8, 16'hDCF8, 16'hDCF0, 16'hDEF8, 16'hDEF0,
        16'hD830, 16'hD838, 16'hDC30, 16'hDC38, 16'hDA30, 16'hDA38, 16'hDE30, 16'hDE38, 16'hDDC0, 16'hDAC0,
        16'hDBC0, 16'hDEC0, 16'hDFF0, 16'hDED9, 16'hDBE2, 16'hDDF0, 16'hD800};

    issue_source src (.clk_i(clk), .issue_ready_i(ready), .issue_valid_o(valid), .opcode_o(opcode),
        .modrm_o(modrm), .wait_prefix_o(wp), .carry_flag_o(cf));

    fpu_divide_cmov_decode uut (.clk_i(clk), .srst_i(srst), .issue_valid_i(valid), .opcode_i(opcode),
        .modrm_i(modrm), .wait_prefix_i(wp), .carry_flag_i(cf), .fp_pending_i(pending),
        .issue_ready_o(ready), .illegal_o(illegal), .op_o(op), .mem_fmt_o(fmt), .mem_first_o(mem_first),
        .dst_o(dst), .opa_o(opa), .opb_o(opb), .write_en_o(we), .pop_cnt_o(pop), .done_o(done),
        .clear_exc_o(clr), .top_o(top), .tag_empty_o(tags));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // Reporting
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish

    // ----------------------------------------
    // Reference decode
    // ----------------------------------------
    task automatic model(input logic [7:0] opc, input logic [7:0] md, input logic c);
        logic [2:0] t;
        logic [2:0] p;
        logic       an;
        t = 3'(m_top);
        p = t + md[2:0];
        an = opc == 8'hDC || (opc == 8'hDE && md[3]);
        e_op = OP_NONE;
        e_fmt = MEM_NONE;
        e_mf = 1'b0;
        e_dst = t;
        e_opa = an ? p : t;
        e_opb = an ? t : p;
        e_we = 1'b0;
        e_pop = 2'h0;
        e_n = 2;
        k_ops = 1'b0;
        if (md[7:6] != 2'h3 && md[5:4] == 2'h3 && opc inside {8'hD8, 8'hDA, 8'hDC, 8'hDE})
        begin
            e_op = opc[1] ? OP_IDIV : OP_DIV;
            e_n = opc[1] ? 34 : 24;
            e_fmt = opc == 8'hDC ? MEM_DOUBLE_REAL : opc == 8'hD8 ? MEM_SINGLE_REAL : opc[2] ? MEM_INT16 : MEM_INT32;
            e_mf = md[3];
            e_opb = t;
            e_we = 1'b1;
        end
        else if (md[7:4] == 4'hF && opc inside {8'hD8, 8'hDC, 8'hDE})
        begin
            e_op = OP_DIV;
            e_n = 24;
            e_dst = (md[3] || opc == 8'hDE) ? p : t;
            k_ops = 1'b1;
            e_we = 1'b1;
            e_pop = {1'b0, opc == 8'hDE};
        end
        else if (md[7:3] == 5'h18 && opc inside {8'hDA, 8'hDB, 8'hDD, 8'hDE})
        begin
            e_op = opc == 8'hDD ? OP_FREE : opc == 8'hDE ? OP_ADD : OP_CMOV;
            e_dst = e_op == OP_CMOV ? t : p;
            e_opa = p;
            e_opb = e_op == OP_ADD ? t : p;
            k_ops = e_op != OP_FREE;
            e_n = e_op == OP_FREE ? 4 : 2;
            e_we = e_op == OP_ADD || (e_op == OP_CMOV && (c ^ opc[0]));
            e_pop = {1'b0, e_op == OP_ADD};
        end
        else if (opc == 8'hDF && md[7:3] == 5'h1E)
        begin
            e_op = OP_COMI;
            e_pop = 2'h1;
            k_ops = 1'b1;
        end
        else if ({opc, md} == 16'hDED9)
        begin
            e_op = OP_COMPP;
            e_pop = 2'h2;
            e_opa = t;
            e_opb = t + 3'h1;
            k_ops = 1'b1;
        end
        else if ({opc, md} == 16'hDBE2)
            e_op = OP_CLEX;
    endtask : model

    // ----------------------------------------
    // One instruction, issue to commit
    // ----------------------------------------
    task automatic run(input logic [15:0] ent, input logic w);
        logic [7:0] opc;
        logic [7:0] md;
        logic       c;
        int         rel;
        int         cyc;
        int         exp_n;
        opc = ent[15:8];
        md = ent[7:0];
        c = 1'($urandom % 2);
        rel = 0;
        if (md[7:6] != 2'h3)
            md = {2'($urandom % 3), md[5:3], 3'($urandom)};
        else if (md != 8'hE2 && md != 8'hD9)
            md = md | 8'($urandom % 8);
        model(opc, md, c);
        exp_n = e_n;
        if (e_op == OP_CLEX)
        begin
            pending = 1'b1;
            if (w)
            begin
                rel = 1 + $urandom % 6;
                exp_n = rel + 2;
            end
        end
        src.send(opc, md, w, c);
        if (e_op == OP_NONE)
        begin
            check(8'(illegal), 8'h01, "illegal flag");
            check(8'(ready), 8'h01, "ready on illegal");
            @(negedge clk);
            check(8'(illegal), 8'h00, "illegal length");
            check(8'(done), 8'h00, "done on illegal");
            return;
        end
        check(8'(op), 8'(e_op), "op kind");
        check(8'(fmt), 8'(e_fmt), "memory format");
        check(8'(mem_first), 8'(e_mf), "memory dividend");
        check(8'(we), 8'(e_we), "write enable");
        check(8'(pop), 8'(e_pop), "pop count");
        check(8'(ready), 8'h00, "busy");
        if (e_we || e_op == OP_FREE)
            check(8'(dst), 8'(e_dst), "destination");
        if (k_ops)
            check(8'(opa), 8'(e_opa), "first operand");
        if (k_ops || e_fmt != MEM_NONE)
            check(8'(opb), 8'(e_opb), "second operand");
        cyc = 1;
        while (done !== 1'b1 && cyc < 60)
        begin
            if (cyc == rel)
                pending = 1'b0;
            @(negedge clk);
            cyc++;
        end
        check(8'(cyc), 8'(exp_n), "clocks to done");
        check(8'(clr), 8'(e_op == OP_CLEX), "clear strobe");
        if (e_we)
            m_tag[e_dst] = 1'b0;
        if (e_op == OP_FREE)
            m_tag[e_dst] = 1'b1;
        for (int i = 0; i < int'(e_pop); i++)
            m_tag[3'(m_top + i)] = 1'b1;
        m_top = (m_top + int'(e_pop)) % 8;
        pending = 1'b0;
        @(negedge clk);
        check(8'(top), 8'(m_top), "top pointer");
        check(tags, m_tag, "empty tags");
        check(8'(ready), 8'h01, "ready again");
        check(8'(done), 8'h00, "done length");
    endtask : run

    task automatic do_reset();
        srst = 1'b1;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        m_top = 0;
        m_tag = 8'hFF;
        check(8'(ready), 8'h01, "ready at reset");
        check(8'(top), 8'h00, "top at reset");
        check(tags, 8'hFF, "tags at reset");
        check(8'(op), 8'(OP_NONE), "op at reset");
        check(8'(done), 8'h00, "done at reset");
        @(negedge clk);
    endtask : do_reset

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        error_cnt = 0;
        cmp_count = 0;
        srst = 1'b1;
        pending = 1'b0;
        seed = $urandom(89671);
        do_reset();
        for (int pass = 0; pass < 3; pass++)
            for (int i = 0; i < 23; i++)
                run(op_table[i], 1'(pass % 2));
        // Reset in mid divide drops the operation
        src.send(8'hDC, 8'hF9, 1'b0, 1'b0);
        repeat (5) @(negedge clk);
        do_reset();
        repeat (30)
        begin
            check(8'(done), 8'h00, "done after abort");
            @(negedge clk);
        end
        run(16'hDEF0, 1'b0);
        tally_and_finish();
    end

    // Whole run needs about 15 us
    initial
    begin
        #60000;
        error_cnt++;
        tally_and_finish();
    end
endmodule : tb_fpu_divide_cmov_decode
`default_nettype wire
